/* File: atcp_ctl.sv */
// Clock source selection, update-busy flags and prescaler reset control.
// Assumes CPU register strobes and the timer tick are synchronous to CLOCK.
// Offsets and field positions come from atcp_consts.svh.
`timescale 1ns/100ps
`include "atcp_consts.svh"
module atcp_ctl (
  input  wire logic           CLOCK,
  input  wire logic           RESET,
  input  wire logic           REG_WR,
  input  wire logic           REG_RD,
  input  wire logic           IO_SPACE,
  input  wire atcp_pkg::atcp_byte_t REG_ADDR,
  input  wire atcp_pkg::atcp_byte_t REG_WDATA,
  input  wire logic           ASYNC_TICK,
  input  wire logic           PSR_ASYNC_DONE,
  output atcp_pkg::atcp_byte_t REG_RDATA,
  output logic                TOSC_BUF_EN,
  output logic                XTAL_OSC_EN,
  output logic                TIMER_CLK_SEL,
  output logic                DIRECT_WRITE,
  output logic [4:0]          UPDATE_LOAD,
  output logic                PRESCALER_ASYNC_RST,
  output logic                PRESCALER_SYNC_RST
);
  import atcp_pkg::*;

  logic       ext_clock_input_enable;
  logic       async_clock_select;
  logic       timer_sync_hold;
  logic       async_prescaler_reset;
  logic       sync_prescaler_reset;
  logic [4:0] busy;
  logic [4:0] req_tog;
  logic [4:0] ack_tog;
  logic [4:0] ack_meta;
  logic [4:0] ack_sync;
  logic [4:0] pend;
  logic       gtc_wr;
  logic       stat_wr;
  logic       gtc_rd;
  logic       stat_rd;
  logic [4:0] hit;
  atcp_byte_t phys_addr;
  atcp_byte_t sync_byte;
  atcp_byte_t status_byte;

  function automatic logic [4:0] target_hit(input atcp_byte_t a);
    logic [4:0] h;
    h = 5'h00;
    h[ATCP_CNT]  = (a == `ATCP_CNT_ADDR);
    h[ATCP_CMPA] = (a == `ATCP_CMPA_ADDR);
    h[ATCP_CMPB] = (a == `ATCP_CMPB_ADDR);
    h[ATCP_CTLA] = (a == `ATCP_CTLA_ADDR);
    h[ATCP_CTLB] = (a == `ATCP_CTLB_ADDR);
    return h;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Address decode; short I/O addresses sit 0x20 below data space.
  assign phys_addr = IO_SPACE ? atcp_byte_t'(REG_ADDR + `ATCP_IO_SPACE_OFFSET)
                              : REG_ADDR;
  assign gtc_wr  = REG_WR && (phys_addr == `ATCP_GTC_DATA_ADDR);
  assign stat_wr = REG_WR && (phys_addr == `ATCP_STATUS_ADDR);
  assign gtc_rd  = REG_RD && (phys_addr == `ATCP_GTC_DATA_ADDR);
  assign stat_rd = REG_RD && (phys_addr == `ATCP_STATUS_ADDR);
  assign hit     = target_hit(phys_addr);

  // Field positions come from the constants, so the busy flags land on
  // their own bits even though the flag array is indexed by target.
  always_comb begin
    sync_byte                      = 8'h00;
    sync_byte[`ATCP_BIT_HOLD]      = timer_sync_hold;
    sync_byte[`ATCP_BIT_PSR_ASYNC] = async_prescaler_reset;
    sync_byte[`ATCP_BIT_PSR_SYNC]  = sync_prescaler_reset;
  end

  always_comb begin
    status_byte                      = 8'h00;
    status_byte[`ATCP_BIT_EXT_CLK]   = ext_clock_input_enable;
    status_byte[`ATCP_BIT_ASYNC_SEL] = async_clock_select;
    status_byte[`ATCP_BIT_CNT_BUSY]  = busy[ATCP_CNT];
    status_byte[`ATCP_BIT_CMPA_BUSY] = busy[ATCP_CMPA];
    status_byte[`ATCP_BIT_CMPB_BUSY] = busy[ATCP_CMPB];
    status_byte[`ATCP_BIT_CTLA_BUSY] = busy[ATCP_CTLA];
    status_byte[`ATCP_BIT_CTLB_BUSY] = busy[ATCP_CTLB];
  end

  // Unmapped addresses and idle reads return zero.
  always_comb begin
    REG_RDATA = 8'h00;
    if (gtc_rd) begin
      REG_RDATA = sync_byte;
    end else if (stat_rd) begin
      REG_RDATA = status_byte;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Clock source. Switching the source does not protect the timer
  // registers; software reloads them afterwards.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ext_clock_input_enable <= 1'b0;
    end else if (stat_wr) begin
      ext_clock_input_enable <= REG_WDATA[`ATCP_BIT_EXT_CLK];
    end
  end

  // Nothing here refuses a select before the ext clock bit; ordering the
  // two writes is left to software.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      async_clock_select <= 1'b0;
    end else if (stat_wr) begin
      async_clock_select <= REG_WDATA[`ATCP_BIT_ASYNC_SEL];
    end
  end

  // The crystal and the external buffer are never on together.

  assign TOSC_BUF_EN   = ext_clock_input_enable && async_clock_select;
  assign XTAL_OSC_EN   = async_clock_select && !ext_clock_input_enable;
  assign TIMER_CLK_SEL = async_clock_select;
  assign DIRECT_WRITE  = !async_clock_select;

  ////////////////////////////////////////////////////////////////////////////
  // Busy flags. A pending transfer completes on the next timer tick and is
  // acknowledged by toggle, so while async stays selected the flag spans a real slow-side load.
  genvar i;
  generate
    for (i = 0; i < `ATCP_NUM_BUSY; i = i + 1) begin : g_busy
      // A write to a busy target sets busy again but sends no second
      // toggle, so the slow side never loads a half-written value twice.
      atcp_busy_flag u_flag (
        .CLOCK            (CLOCK),
        .RESET            (RESET),
        .write_async      (REG_WR && async_clock_select &&
                           hit[i]),
        .done_toggle_sync (ack_sync[i]),
        .busy             (busy[i]),
        .req_toggle       (req_tog[i])
      );
      // Back on io_clock no tick arrives, so an unfinished transfer is
      // dropped; this lets the busy flag fall instead of hanging.
      always_ff @(posedge CLOCK) begin
        if (RESET) begin
          ack_tog[i] <= 1'b0;
        end else if (!async_clock_select) begin
          ack_tog[i] <= req_tog[i];
        end else if (ASYNC_TICK && pend[i]) begin
          ack_tog[i] <= req_tog[i];
        end
      end
      assign pend[i] = req_tog[i] != ack_tog[i];
      // In io_clock mode the load strobe follows the write directly, so the
      // timer sees the new value on the next edge with nothing pending.
      assign UPDATE_LOAD[i] = async_clock_select ? (ASYNC_TICK && pend[i])
                            : (REG_WR && hit[i]);
    end
  endgenerate

  // The acknowledge is already in this clock domain; the two stages are
  // kept so the busy time matches a slow-side load seen through a
  // synchroniser, which software relies on when it polls.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      ack_meta <= 5'h00;
      ack_sync <= 5'h00;
    end else begin
      ack_meta <= ack_tog;
      ack_sync <= ack_meta;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Synchronisation hold and prescaler resets. A fresh write wins over the
  // self-clear in the same cycle. Writing the hold bit to zero ends a held
  // reset even if the same write asks for that reset again; a write that
  // asks for a reset with hold already off starts a new one.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      timer_sync_hold <= 1'b0;
    end else if (gtc_wr) begin
      timer_sync_hold <= REG_WDATA[`ATCP_BIT_HOLD];
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      async_prescaler_reset <= 1'b0;
    end else if (gtc_wr && REG_WDATA[`ATCP_BIT_HOLD]) begin
      async_prescaler_reset <= REG_WDATA[`ATCP_BIT_PSR_ASYNC];
    end else if (gtc_wr && (timer_sync_hold ||
                            !REG_WDATA[`ATCP_BIT_PSR_ASYNC])) begin
      async_prescaler_reset <= 1'b0;
    end else if (gtc_wr) begin
      async_prescaler_reset <= 1'b1;
    end else if (!timer_sync_hold &&
                 (!async_clock_select || PSR_ASYNC_DONE)) begin
      async_prescaler_reset <= 1'b0;
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      sync_prescaler_reset <= 1'b0;
    end else if (gtc_wr && REG_WDATA[`ATCP_BIT_HOLD]) begin
      sync_prescaler_reset <= REG_WDATA[`ATCP_BIT_PSR_SYNC];
    end else if (gtc_wr && (timer_sync_hold ||
                            !REG_WDATA[`ATCP_BIT_PSR_SYNC])) begin
      sync_prescaler_reset <= 1'b0;
    end else if (gtc_wr) begin
      sync_prescaler_reset <= 1'b1;
    end else if (!timer_sync_hold) begin
      sync_prescaler_reset <= 1'b0;
    end
  end

  // A write with hold clear still pulses the reset for that cycle.
  assign PRESCALER_ASYNC_RST = async_prescaler_reset ||
      (gtc_wr && REG_WDATA[`ATCP_BIT_PSR_ASYNC]);
  assign PRESCALER_SYNC_RST  = sync_prescaler_reset ||
      (gtc_wr && REG_WDATA[`ATCP_BIT_PSR_SYNC]);
endmodule

/* File: atcp_consts.svh */
// Constants for the asynchronous timer clock and prescaler control block.
// Assumes a CPU-side byte register port with separate read and write strobes.
//
// What this block does
// - Ext clock bit set with async select enables oscillator-one input buffer.
// - Crystal oscillator runs only while the ext clock bit is zero.
// - Async select zero clocks timer from io_clock, one from oscillator.
// - Counter, compares and controls may be corrupted on source switch.
// - Async counter write sets busy; cleared once counter loaded.
// - Async compare A write sets busy; cleared after transfer.
// - Async compare B write sets busy; cleared after transfer.
// - Async control A write sets busy; cleared after transfer.
// - Async control B write sets busy; cleared after transfer.
// - Sync hold set keeps written prescaler-reset bits asserted.
// - Writing sync hold zero while hold is set clears both prescaler-reset bits.
// - Async prescaler reset self-clears, waits in async mode, kept under hold.
// - Sync prescaler reset resets shared prescaler, self-clears unless hold.
// - Sync control register decoded at data 0x43 and I/O 0x23.
`ifndef ATCP_CONSTS_SVH
`define ATCP_CONSTS_SVH
`define ATCP_GTC_DATA_ADDR   8'h43
`define ATCP_IO_SPACE_OFFSET 8'h20
`define ATCP_GTC_IO_ADDR     8'h23
`define ATCP_STATUS_ADDR     8'hB6
`define ATCP_CNT_ADDR        8'hB2
`define ATCP_CMPA_ADDR       8'hB3
`define ATCP_CMPB_ADDR       8'hB4
`define ATCP_CTLA_ADDR       8'hB0
`define ATCP_CTLB_ADDR       8'hB1
`define ATCP_GTC_RESET       8'h00
`define ATCP_STATUS_RESET    8'h00
`define ATCP_BIT_HOLD        7
`define ATCP_BIT_PSR_ASYNC   1
`define ATCP_BIT_PSR_SYNC    0
`define ATCP_BIT_EXT_CLK     6
`define ATCP_BIT_ASYNC_SEL   5
`define ATCP_BIT_CNT_BUSY    4
`define ATCP_BIT_CMPA_BUSY   3
`define ATCP_BIT_CMPB_BUSY   2
`define ATCP_BIT_CTLA_BUSY   1
`define ATCP_BIT_CTLB_BUSY   0
`define ATCP_NUM_BUSY        5
`endif

/* File: atcp_pkg.sv */
// Types for the asynchronous timer clock and prescaler control block.
// Assumes atcp_consts.svh is compiled alongside.
package atcp_pkg;
  typedef logic [7:0] atcp_byte_t;
  typedef enum logic [2:0] {
    ATCP_CNT, ATCP_CMPA, ATCP_CMPB, ATCP_CTLA, ATCP_CTLB
  } atcp_target_t;
endpackage

/* File: atcp_busy_flag.sv */
// One update-busy flag with a toggle handshake towards the timer clock.
// Assumes the transfer acknowledge comes back already synchronised.
`timescale 1ns/100ps
module atcp_busy_flag (
  input  wire logic CLOCK,
  input  wire logic RESET,
  input  wire logic write_async,
  input  wire logic done_toggle_sync,
  output logic      busy,
  output logic      req_toggle
);
  import atcp_pkg::*;
  logic done_seen;

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      req_toggle <= 1'b0;
    end else if (write_async && !busy) begin
      req_toggle <= ~req_toggle;
    end
  end

  // Busy ends when the synchronised done toggle changes level.
  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      busy      <= 1'b0;
      done_seen <= 1'b0;
    end else begin
      done_seen <= done_toggle_sync;
      if (write_async) begin
        busy <= 1'b1;
      end else if (done_toggle_sync != done_seen) begin
        busy <= 1'b0;
      end
    end
  end
endmodule

/* File: atcp_ctl_monitor.sv */
// Checker for the timer clock and prescaler control block.
// Assumes it is bound to atcp_ctl and watches only its ports.
`timescale 1ns/100ps
`include "atcp_consts.svh"
module atcp_ctl_monitor (
  input wire logic                 CLOCK,
  input wire logic                 RESET,
  input wire logic                 REG_WR,
  input wire logic                 IO_SPACE,
  input wire atcp_pkg::atcp_byte_t REG_ADDR,
  input wire atcp_pkg::atcp_byte_t REG_WDATA,
  input wire logic                 ASYNC_TICK,
  input wire logic                 TOSC_BUF_EN,
  input wire logic                 XTAL_OSC_EN,
  input wire logic                 TIMER_CLK_SEL,
  input wire logic                 DIRECT_WRITE,
  input wire logic [4:0]           UPDATE_LOAD,
  input wire logic                 PRESCALER_ASYNC_RST,
  input wire logic                 PRESCALER_SYNC_RST
);
  import atcp_pkg::*;
  logic wr_sy;
  logic wr_st;
  assign wr_sy = REG_WR && REG_ADDR == (IO_SPACE ? `ATCP_GTC_IO_ADDR
                                                 : `ATCP_GTC_DATA_ADDR);
  assign wr_st = REG_WR && !IO_SPACE && REG_ADDR == `ATCP_STATUS_ADDR;
  default clocking @(posedge CLOCK); endclocking
  default disable iff (RESET);
  AST_EXT_BUF: assert property (wr_st && REG_WDATA[6:5] == 2'b11
    |=> TOSC_BUF_EN && !XTAL_OSC_EN) else $error("buffer state");
  AST_XTAL: assert property (wr_st && REG_WDATA[6:5] == 2'b01
    |=> XTAL_OSC_EN && !TOSC_BUF_EN) else $error("crystal state");
  AST_SRC_SEL: assert property (wr_st |=> DIRECT_WRITE != TIMER_CLK_SEL
    && TIMER_CLK_SEL == $past(REG_WDATA[5])) else $error("clock source");
  AST_IO_DIRECT: assert property (DIRECT_WRITE && wr_st == 0 && REG_WR
    && !IO_SPACE && REG_ADDR == `ATCP_CNT_ADDR |-> UPDATE_LOAD[0])
    else $error("direct load");
  AST_LOAD_ON_TICK: assert property (TIMER_CLK_SEL && |UPDATE_LOAD
    |-> ASYNC_TICK) else $error("load without tick");
  AST_HOLD_KEEP: assert property (wr_sy && REG_WDATA == 8'h83
    ##1 !REG_WR [*4] |-> PRESCALER_SYNC_RST && PRESCALER_ASYNC_RST)
    else $error("hold lost");
  AST_HOLD_CLEAR: assert property (wr_sy && REG_WDATA == 8'h00 |=>
    REG_WR || !(PRESCALER_SYNC_RST || PRESCALER_ASYNC_RST))
    else $error("hold clear");
  AST_SYNC_PULSE: assert property (wr_sy && REG_WDATA[0]
    |-> PRESCALER_SYNC_RST) else $error("sync reset pulse");
  AST_SYNC_SELF_CLR: assert property (wr_sy && REG_WDATA == 8'h01
    ##1 !REG_WR [*2] |-> !PRESCALER_SYNC_RST)
    else $error("sync reset");
endmodule
////////////////////////////////////////////////////////////////////////
bind atcp_ctl atcp_ctl_monitor u_atcp_ctl_monitor (
  .CLOCK               (CLOCK),
  .RESET               (RESET),
  .REG_WR              (REG_WR),
  .IO_SPACE            (IO_SPACE),
  .REG_ADDR            (REG_ADDR),
  .REG_WDATA           (REG_WDATA),
  .ASYNC_TICK          (ASYNC_TICK),
  .TOSC_BUF_EN         (TOSC_BUF_EN),
  .XTAL_OSC_EN         (XTAL_OSC_EN),
  .TIMER_CLK_SEL       (TIMER_CLK_SEL),
  .DIRECT_WRITE        (DIRECT_WRITE),
  .UPDATE_LOAD         (UPDATE_LOAD),
  .PRESCALER_ASYNC_RST (PRESCALER_ASYNC_RST),
  .PRESCALER_SYNC_RST  (PRESCALER_SYNC_RST)
);

/* File: test_atcp_ctl.sv */
// Testbench for the timer clock and prescaler control block.
// Assumes the package, constants and checker are compiled first.
`timescale 1ns/100ps
`include "atcp_consts.svh"
module test_atcp_ctl;
  import atcp_pkg::*;
  logic       CLOCK = 0, RESET = 1, REG_WR = 0, REG_RD = 0, IO_SPACE = 0;
  logic       ASYNC_TICK = 0, PSR_ASYNC_DONE = 0, srst_seen;
  logic       TOSC_BUF_EN, XTAL_OSC_EN, TIMER_CLK_SEL, DIRECT_WRITE;
  logic       PRESCALER_ASYNC_RST, PRESCALER_SYNC_RST;
  logic [4:0] UPDATE_LOAD, load_seen;
  atcp_byte_t REG_ADDR = 0, REG_WDATA = 0, REG_RDATA;
  atcp_byte_t tgt [5] = '{8'hB2, 8'hB3, 8'hB4, 8'hB0, 8'hB1};
  int         miscompares = 0, cmp_count = 0, cycles = 0;
  atcp_ctl u_atcp_ctl (
    .CLOCK               (CLOCK),
    .RESET               (RESET),
    .REG_WR              (REG_WR),
    .REG_RD              (REG_RD),
    .IO_SPACE            (IO_SPACE),
    .REG_ADDR            (REG_ADDR),
    .REG_WDATA           (REG_WDATA),
    .ASYNC_TICK          (ASYNC_TICK),
    .PSR_ASYNC_DONE      (PSR_ASYNC_DONE),
    .REG_RDATA           (REG_RDATA),
    .TOSC_BUF_EN         (TOSC_BUF_EN),
    .XTAL_OSC_EN         (XTAL_OSC_EN),
    .TIMER_CLK_SEL       (TIMER_CLK_SEL),
    .DIRECT_WRITE        (DIRECT_WRITE),
    .UPDATE_LOAD         (UPDATE_LOAD),
    .PRESCALER_ASYNC_RST (PRESCALER_ASYNC_RST),
    .PRESCALER_SYNC_RST  (PRESCALER_SYNC_RST)
  );
  initial forever #10 CLOCK = ~CLOCK;
  always @(posedge CLOCK) begin
    cycles++;
    if (cycles == 5000) begin
      miscompares++;
      tally_and_finish();
    end
  end
  task automatic chk(string n, logic [7:0] seen, logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, exp, seen);
    end
  endtask
  task automatic wr(logic io, atcp_byte_t a, atcp_byte_t d);
    @(posedge CLOCK);
    REG_WR <= 1'b1;
    IO_SPACE <= io;
    REG_ADDR <= a;
    REG_WDATA <= d;
    @(negedge CLOCK);
    load_seen = UPDATE_LOAD;
    srst_seen = PRESCALER_SYNC_RST;
    @(posedge CLOCK);
    REG_WR <= 1'b0;
  endtask
  task automatic rd(logic io, atcp_byte_t a, atcp_byte_t e);
    @(posedge CLOCK);
    REG_RD <= 1'b1;
    IO_SPACE <= io;
    REG_ADDR <= a;
    @(negedge CLOCK);
    chk("rdata", REG_RDATA, e);
  endtask
  // Pins packed as buffer, crystal, source select, direct write.
  task automatic pins(logic [3:0] e);
    @(negedge CLOCK);
    chk("pins", {4'h0, TOSC_BUF_EN, XTAL_OSC_EN, TIMER_CLK_SEL,
        DIRECT_WRITE}, {4'h0, e});
  endtask
  task automatic psr(logic [1:0] e, int n);
    repeat (n) @(negedge CLOCK);
    chk("psr", {6'h0, PRESCALER_ASYNC_RST, PRESCALER_SYNC_RST}, {6'h0, e});
  endtask
  task automatic t_reset();
    rd(0, 8'h43, 8'h00);
    rd(0, `ATCP_STATUS_ADDR, 8'h00);
    rd(0, 8'h44, 8'h00);
  endtask
  task automatic t_source();
    // The ext clock bit goes in first, while still on io_clock.
    wr(0, `ATCP_STATUS_ADDR, 8'h40);
    pins(4'h1);
    wr(0, `ATCP_STATUS_ADDR, 8'h60);
    pins(4'hA);
    rd(0, `ATCP_STATUS_ADDR, 8'h60);
    wr(0, `ATCP_STATUS_ADDR, 8'h20);
    pins(4'h6);
    wr(0, `ATCP_STATUS_ADDR, 8'h1F);
    pins(4'h1);
    rd(0, `ATCP_STATUS_ADDR, 8'h00);
  endtask
  task automatic t_direct();
    for (int i = 0; i < 5; i++) begin
      wr(0, tgt[i], 8'hA5);
      chk("load", {3'h0, load_seen}, 8'h01 << i);
      rd(0, `ATCP_STATUS_ADDR, 8'h00);
    end
  endtask
  task automatic t_busy();
    wr(0, `ATCP_STATUS_ADDR, 8'h20);
    // Each target is written only after its busy flag has dropped.
    for (int i = 0; i < 5; i++) begin
      wr(0, tgt[i], 8'h5A);
      chk("load", {3'h0, load_seen}, 8'h00);
      rd(0, `ATCP_STATUS_ADDR, 8'h20 | (8'h10 >> i));
      @(posedge CLOCK);
      ASYNC_TICK <= 1'b1;
      @(negedge CLOCK);
      chk("tick", {3'h0, UPDATE_LOAD}, 8'h01 << i);
      @(posedge CLOCK);
      ASYNC_TICK <= 1'b0;
      rd(0, `ATCP_STATUS_ADDR, 8'h20 | (8'h10 >> i));
      // The acknowledge needs three edges after the tick to clear busy.
      @(posedge CLOCK);
      rd(0, `ATCP_STATUS_ADDR, 8'h20);
    end
  endtask
  task automatic t_prescaler();
    wr(0, 8'h43, 8'h02);
    psr(2'b10, 4);
    @(posedge CLOCK);
    PSR_ASYNC_DONE <= 1'b1;
    @(posedge CLOCK);
    PSR_ASYNC_DONE <= 1'b0;
    psr(2'b00, 3);
    wr(0, `ATCP_STATUS_ADDR, 8'h00);
    wr(1, 8'h23, 8'h01);
    chk("write_cycle", {7'h0, srst_seen}, 8'h01);
    psr(2'b01, 1);
    psr(2'b00, 1);
    wr(0, 8'h43, 8'h02);
    psr(2'b10, 1);
    psr(2'b00, 1);
    wr(0, 8'h43, 8'h83);
    psr(2'b11, 5);
    rd(1, 8'h23, 8'h83);
    wr(0, 8'h43, 8'h00);
    psr(2'b00, 1);
  endtask
  task automatic tally_and_finish();
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge CLOCK);
    RESET <= 1'b0;
    t_reset();
    t_source();
    t_direct();
    t_busy();
    t_prescaler();
    tally_and_finish();
  end
endmodule
